// ==== rtl/rces_pkg.sv ====
/*
 * Shared constants, types and helpers for the receive client status block.
 * Assumes a 256-bit receive stream split into four 64-bit words, with byte 0
 * of word 0 in the lowest bits.
 */
package rces_pkg;

    // ---------------------------------------------------------------
    // Stream geometry
    // ---------------------------------------------------------------
    localparam int         WORDS      = 4;
    localparam int         BYTES      = 8;
    localparam logic [3:0] WORD_BYTES = 4'h8;
    localparam logic [7:0] TERM_CHAR  = 8'hfd;

    // ---------------------------------------------------------------
    // Frame length limits
    // ---------------------------------------------------------------
    localparam logic [15:0] RUNT_MAX    = 16'h0008;
    localparam logic [15:0] MIN_FRAME   = 16'h0040;
    localparam logic [15:0] TYPE_MIN    = 16'h0600;
    localparam logic [15:0] HDR_FCS     = 16'h0012;
    localparam logic [15:0] MIN_PAYLOAD = 16'h002e;
    localparam logic [15:0] LEN_HI_POS  = 16'h000c;
    localparam logic [15:0] LEN_LO_POS  = 16'h000d;

    // ---------------------------------------------------------------
    // Error vector bit positions
    // ---------------------------------------------------------------
    localparam int ERR_MALF  = 0;
    localparam int ERR_CRC   = 1;
    localparam int ERR_UNDER = 2;
    localparam int ERR_OVER  = 3;
    localparam int ERR_PLEN  = 4;
    localparam int ERR_RSVD  = 5;

    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [15:0] IDX_MAX_SIZE  = 16'h0506;
    localparam logic [15:0] IDX_PLEN_CTRL = 16'h050a;
    localparam logic [15:0] IDX_STATUS    = 16'h050c;
    localparam logic [15:0] MAX_SIZE_RST  = 16'h05ee;
    localparam int          PLEN_EN_BIT   = 0;

    typedef enum logic {
        ST_GAP   = 1'b0,
        ST_FRAME = 1'b1
    } rces_rx_st_t;

    function automatic logic [15:0] rces_addr_of(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction

    // Widens a per-word flag to the three empty-count bits of that word
    function automatic logic [11:0] rces_spread3(input logic [3:0] v);
        return {{3{v[3]}}, {3{v[2]}}, {3{v[1]}}, {3{v[0]}}};
    endfunction

endpackage

// ==== rtl/rces_frame_scan.sv ====
/*
 * Combinational walk over the four words of one cycle: tracks frame
 * boundaries, counts bytes, catches the length field and stray control bytes.
 * Assumes one-hot start and end markers and the running state held outside.
 */
`timescale 1ns/1ps
module rces_frame_scan (
    input  wire logic [255:0] in_d,
    input  wire logic [31:0]  in_c,
    input  wire logic [3:0]   in_sop,
    input  wire logic [3:0]   in_eop,
    input  wire logic [11:0]  in_eop_empty,
    input  wire logic         cur_infr,
    input  wire logic [15:0]  cur_cnt,
    input  wire logic [15:0]  cur_lenf,
    input  wire logic         cur_malf,
    output logic              nxt_infr,
    output logic [15:0]       nxt_cnt,
    output logic [15:0]       nxt_lenf,
    output logic              nxt_malf,
    output logic [3:0]        idle,
    output logic              fin,
    output logic [15:0]       fin_len,
    output logic [15:0]       fin_lenf,
    output logic              fin_malf
);
    logic [3:0]  nb;
    logic [7:0]  bt;
    logic [15:0] pos;

    always_comb begin
        nb       = rces_pkg::WORD_BYTES;
        bt       = 8'h00;
        pos      = 16'h0000;
        nxt_infr = cur_infr;
        nxt_cnt  = cur_cnt;
        nxt_lenf = cur_lenf;
        nxt_malf = cur_malf;
        idle     = 4'h0;
        fin      = 1'b0;
        fin_len  = 16'h0000;
        fin_lenf = 16'h0000;
        fin_malf = 1'b0;
        for (int k = 0; k < rces_pkg::WORDS; k++) begin
            if (in_sop[k]) begin
                nxt_infr = 1'b1;
                nxt_cnt  = 16'h0000;
                nxt_lenf = 16'h0000;
                nxt_malf = 1'b0;
            end
            nb = in_eop[k] ? rces_pkg::WORD_BYTES - {1'b0, in_eop_empty[3*k +: 3]} : rces_pkg::WORD_BYTES;
            if (!nxt_infr) begin
                idle[k] = 1'b1;
            end else begin
                for (int j = 0; j < rces_pkg::BYTES; j++) begin
                    bt  = in_d[64*k + 8*j +: 8];
                    pos = nxt_cnt + 16'(j);
                    if (4'(j) < nb) begin
                        if (in_c[8*k + j] && bt != rces_pkg::TERM_CHAR) begin
                            nxt_malf = 1'b1;
                        end
                        if (pos == rces_pkg::LEN_HI_POS) begin
                            nxt_lenf[15:8] = bt;
                        end
                        if (pos == rces_pkg::LEN_LO_POS) begin
                            nxt_lenf[7:0] = bt;
                        end
                    end
                end
                // No saturation: a frame never runs near 64 KiB
                nxt_cnt = nxt_cnt + {12'h000, nb};
                if (in_eop[k]) begin
                    fin      = 1'b1;
                    fin_len  = nxt_cnt;
                    fin_lenf = nxt_lenf;
                    fin_malf = nxt_malf;
                    nxt_infr = 1'b0;
                end
            end
        end
    end

endmodule

// ==== rtl/rces_err_eval.sv ====
/*
 * Turns the summary of a finished frame into the six-bit error vector.
 * Assumes the length counts every byte up to and including the checksum.
 */
`timescale 1ns/1ps
module rces_err_eval (
    input  wire logic        fin,
    input  wire logic [15:0] len,
    input  wire logic [15:0] lenf,
    input  wire logic        malf,
    input  wire logic        crc_bad,
    input  wire logic [15:0] max_size,
    input  wire logic        plen_en,
    output logic [5:0]       err
);
    logic        runt;
    logic [15:0] payload;
    logic [15:0] expect_len;

    always_comb begin
        runt       = len <= rces_pkg::RUNT_MAX;
        payload    = len - rces_pkg::HDR_FCS;
        // Short payloads are padded, so the padded size is what arrives
        expect_len = (lenf < rces_pkg::MIN_PAYLOAD) ? rces_pkg::MIN_PAYLOAD : lenf;
        err        = 6'h00;
        if (fin) begin
            // A runt is a decoding fault, not a frame: only the malformed flag
            err[rces_pkg::ERR_MALF] = malf | runt;
            if (!runt) begin
                err[rces_pkg::ERR_CRC]   = crc_bad;
                err[rces_pkg::ERR_UNDER] = len < rces_pkg::MIN_FRAME;
                err[rces_pkg::ERR_OVER]  = len > max_size;
                err[rces_pkg::ERR_PLEN]  = plen_en && len >= rces_pkg::HDR_FCS
                                           && lenf < rces_pkg::TYPE_MIN && payload != expect_len;
            end
        end
        err[rces_pkg::ERR_RSVD] = 1'b0;
    end

endmodule

// ==== rtl/rces_rx_status.sv ====
/*
 * Receive client status: idle and end-of-packet markers, empty counts and the
 * per-frame error vector, plus an APB slave for the length configuration.
 * Assumes the stream arrives synchronous to pclk with checksum bytes kept and
 * the checksum verdict given in the end-of-packet cycle.
 */
//
// Behaviour
// - Flag each 64-bit word holding idle or control bytes instead of payload.
// - Six-bit error vector, meaningful only in end-of-packet cycles.
// - Vector pairs with its frame only with end aligned to checksum word.
// - Bit 0 set on a non-terminate control byte inside a frame.
// - Bit 1 set on checksum failure, identical to the checksum-error output.
// - Bit 2 set for frames of nine through 63 bytes.
// - Eight bytes or fewer is no frame and never reported undersized.
// - Bit 3 set when length exceeds the programmed maximum frame size.
// - Bit 4 set when payload disagrees with a length field below 1536.
// - Bit 4 reported only while length-check control bit 0 is one.
// - Every client output is clocked on the receive clock.
// - One-hot marker of the word holding the frame's last byte.
// - Three empty-byte bits per word, zero unless that word ends a frame.
`timescale 1ns/1ps
module rces_rx_status (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [15:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [255:0] in_d,
    input  wire logic [31:0]  in_c,
    input  wire logic [3:0]   in_sop,
    input  wire logic [3:0]   in_eop,
    input  wire logic [11:0]  in_eop_empty,
    input  wire logic         in_crc_bad,
    output logic [3:0]        rx_idle,
    output logic [3:0]        rx_eop,
    output logic [11:0]       rx_eop_empty,
    output logic [5:0]        rx_error,
    output logic              rx_fcs_error
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        rces_pkg::rces_rx_st_t st;
        logic [15:0]           cnt;
        logic [15:0]           lenf;
        logic                  malf;
        logic [3:0]            idle;
        logic [3:0]            eop;
        logic [11:0]           empty;
        logic [5:0]            err;
        logic                  fcs;
        logic [5:0]            last_err;
        logic [15:0]           frames;
        logic [15:0]           max_size;
        logic                  plen_en;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
    } rces_rx_state_t;

    rces_rx_state_t s_q;
    rces_rx_state_t s_d;

    logic        scan_infr;
    logic [15:0] scan_cnt;
    logic [15:0] scan_lenf;
    logic        scan_malf;
    logic [3:0]  scan_idle;
    logic        scan_fin;
    logic [15:0] scan_len;
    logic [15:0] scan_flenf;
    logic        scan_fmalf;
    logic [5:0]  eval_err;

    logic        hit_max;
    logic        hit_plen;
    logic        hit_stat;
    logic [31:0] rd_val;

    // ---------------------------------------------------------------
    // Frame walk and error evaluation
    // ---------------------------------------------------------------
    rces_frame_scan u_scan (
        .in_d         (in_d),
        .in_c         (in_c),
        .in_sop       (in_sop),
        .in_eop       (in_eop),
        .in_eop_empty (in_eop_empty),
        .cur_infr     (s_q.st == rces_pkg::ST_FRAME),
        .cur_cnt      (s_q.cnt),
        .cur_lenf     (s_q.lenf),
        .cur_malf     (s_q.malf),
        .nxt_infr     (scan_infr),
        .nxt_cnt      (scan_cnt),
        .nxt_lenf     (scan_lenf),
        .nxt_malf     (scan_malf),
        .idle         (scan_idle),
        .fin          (scan_fin),
        .fin_len      (scan_len),
        .fin_lenf     (scan_flenf),
        .fin_malf     (scan_fmalf)
    );

    rces_err_eval u_eval (
        .fin      (scan_fin),
        .len      (scan_len),
        .lenf     (scan_flenf),
        .malf     (scan_fmalf),
        .crc_bad  (in_crc_bad),
        .max_size (s_q.max_size),
        .plen_en  (s_q.plen_en),
        .err      (eval_err)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        hit_max  = paddr == rces_pkg::rces_addr_of(rces_pkg::IDX_MAX_SIZE);
        hit_plen = paddr == rces_pkg::rces_addr_of(rces_pkg::IDX_PLEN_CTRL);
        hit_stat = paddr == rces_pkg::rces_addr_of(rces_pkg::IDX_STATUS);
        rd_val   = 32'h0000_0000;

        s_d.st    = scan_infr ? rces_pkg::ST_FRAME : rces_pkg::ST_GAP;
        s_d.cnt   = scan_cnt;
        s_d.lenf  = scan_lenf;
        s_d.malf  = scan_malf;
        s_d.idle  = scan_idle;
        s_d.eop   = in_eop;
        s_d.empty = in_eop_empty & rces_pkg::rces_spread3(in_eop);
        // Evaluator yields zero unless a frame ends this cycle
        s_d.err   = eval_err;
        // Taken from the vector itself so a runt never splits the two apart
        s_d.fcs   = eval_err[rces_pkg::ERR_CRC];
        if (scan_fin) begin
            s_d.last_err = eval_err;
            s_d.frames   = s_q.frames + 16'h0001;
        end

        if (hit_max) begin
            rd_val[15:0] = s_q.max_size;
        end
        if (hit_plen) begin
            rd_val[rces_pkg::PLEN_EN_BIT] = s_q.plen_en;
        end
        if (hit_stat) begin
            rd_val = {s_q.frames, 7'h00, s_q.st == rces_pkg::ST_FRAME, 2'h0, s_q.last_err};
        end

        // Answer prepared in setup so every bus output leaves a flop
        s_d.pready = psel & ~penable;
        if (psel && !penable) begin
            s_d.prdata  = rd_val;
            s_d.pslverr = !(hit_max || hit_plen || hit_stat);
        end
        if (psel && penable && s_q.pready && pwrite) begin
            if (hit_max) begin
                s_d.max_size = pwdata[15:0];
            end
            if (hit_plen) begin
                s_d.plen_en = pwdata[rces_pkg::PLEN_EN_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.max_size <= rces_pkg::MAX_SIZE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata       = s_q.prdata;
    assign pready       = s_q.pready;
    assign pslverr      = s_q.pslverr;
    assign rx_idle      = s_q.idle;
    assign rx_eop       = s_q.eop;
    assign rx_eop_empty = s_q.empty;
    // Aligned to the end word by construction, so the pairing always holds
    assign rx_error     = s_q.err;
    assign rx_fcs_error = s_q.fcs;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        rx_error[rces_pkg::ERR_RSVD] == 1'b0)
        else $error("reserved error bit set");

    chk_err_needs_eop: assert property (@(posedge pclk) disable iff (!presetn)
        rx_error != 6'h00 |-> rx_eop != 4'h0)
        else $error("error vector outside end cycle");

    chk_eop_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(rx_eop))
        else $error("end marker not one-hot");

    chk_empty_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_eop_empty & ~rces_pkg::rces_spread3(rx_eop)) == 12'h000)
        else $error("empty count on a non-end word");

    chk_fcs_same: assert property (@(posedge pclk) disable iff (!presetn)
        rx_error[rces_pkg::ERR_CRC] == rx_fcs_error)
        else $error("checksum bit and output differ");

    chk_crc_follow: assert property (@(posedge pclk) disable iff (!presetn)
        in_eop != 4'h0 && in_crc_bad && s_q.st == rces_pkg::ST_FRAME && in_sop == 4'h0
        && s_q.cnt >= rces_pkg::RUNT_MAX |=> rx_error[rces_pkg::ERR_CRC] && rx_fcs_error)
        else $error("checksum failure not reported");

    chk_plen_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(s_q.plen_en) |-> !rx_error[rces_pkg::ERR_PLEN])
        else $error("length error while check disabled");

    chk_idle_gap: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.st == rces_pkg::ST_GAP && in_sop == 4'h0 |=> rx_idle == 4'hf)
        else $error("gap words not flagged idle");

    chk_malf_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        in_sop == 4'h1 && in_eop != 4'h0 && in_c[0] && in_d[7:0] != rces_pkg::TERM_CHAR
        |=> rx_error[rces_pkg::ERR_MALF])
        else $error("stray control byte not flagged");

    chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not a single access cycle");

endmodule

// ==== bench/rces_client_model.sv ====
/*
 * Client-side model: keeps the error vector of the most recent finished frame.
 * Assumes the status block's registered outputs, all on pclk.
 */
`timescale 1ns/1ps
module rces_client_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] rx_eop,
    input  wire logic [5:0] rx_error,
    output logic [5:0]      last_err_q
);
    // Vector taken only in end cycles; otherwise it carries no meaning
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_err_q <= 6'h00;
        end else if (rx_eop != 4'h0) begin
            last_err_q <= rx_error;
        end
    end
endmodule

// ==== bench/rces_rx_status_tb_top.sv ====
/*
 * Self-checking bench for the receive status block: APB register access,
 * framed stream traffic with corner and random lengths, errors injected.
 * Assumes zero-wait APB and outputs one cycle after the stream input.
 */
`timescale 1ns/1ps
module rces_rx_status_tb_top;
    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [15:0]  paddr;
    logic [31:0]  pwdata;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [255:0] in_d;
    logic [31:0]  in_c;
    logic [3:0]   in_sop;
    logic [3:0]   in_eop;
    logic [11:0]  in_eop_empty;
    logic         in_crc_bad;
    logic [3:0]   rx_idle;
    logic [3:0]   rx_eop;
    logic [11:0]  rx_eop_empty;
    logic [5:0]   rx_error;
    logic         rx_fcs_error;
    logic [5:0]   last_err_q;
    logic [5:0]   last_exp;
    logic [31:0]  rng;
    logic [15:0]  max_sz;
    logic         plen_en;
    logic [31:0]  rd;
    logic         err;
    int           failures;
    int           num_checks;
    int           frames_sent;
    int           corner_len [7] = '{8, 9, 18, 63, 64, 1518, 1519};

    rces_rx_status dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_d(in_d), .in_c(in_c),
        .in_sop(in_sop), .in_eop(in_eop), .in_eop_empty(in_eop_empty), .in_crc_bad(in_crc_bad),
        .rx_idle(rx_idle), .rx_eop(rx_eop), .rx_eop_empty(rx_eop_empty), .rx_error(rx_error),
        .rx_fcs_error(rx_fcs_error)
    );
    rces_client_model client (.pclk(pclk), .presetn(presetn), .rx_eop(rx_eop), .rx_error(rx_error),
                              .last_err_q(last_err_q));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [5:0] exp_err(input int len, input logic [15:0] lf, input logic m, input logic c);
        logic [5:0] e;
        int         want;
        want = (lf < rces_pkg::MIN_PAYLOAD) ? 46 : int'(lf);
        if (len <= 8) return 6'h01;
        e = 6'h00;
        e[0] = m;
        e[1] = c;
        e[2] = (len <= 63);
        e[3] = (len > int'(max_sz));
        e[4] = plen_en && (len >= 18) && (lf < rces_pkg::TYPE_MIN) && (len - 18 != want);
        return e;
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic drv(input logic [255:0] d, input logic [31:0] c, input logic [3:0] s, input logic [3:0] e,
                       input logic [11:0] em, input logic cb);
        @(posedge pclk);
        in_d <= d;
        in_c <= c;
        in_sop <= s;
        in_eop <= e;
        in_eop_empty <= em;
        in_crc_bad <= cb;
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Ends once pready is seen high; the watchdog only catches a hang
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        chk("pready wait", n, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Frame from word 0; mode 1 stray control byte, mode 2 terminate byte, mode 3 control at byte 0
    task automatic send(input int len, input logic [15:0] lf, input int mode, input logic cb);
        logic [255:0] d;
        logic [31:0]  c;
        logic [11:0]  em;
        int           ncyc;
        int           pos;
        int           ew;
        int           b;
        ncyc = (len + 31) / 32;
        ew = ((len - 1) % 32) / 8;
        em = 12'(7 - (len - 1) % 8) << (3 * ew);
        rng = xs(rng);
        pos = (mode == 3) ? 0 : (mode != 0 && len > 14) ? 14 + int'(rng[15:0]) % (len - 14) : -1;
        last_exp = exp_err(len, lf, pos >= 0 && mode != 2, cb);
        frames_sent++;
        for (int i = 0; i < ncyc; i++) begin
            for (int k = 0; k < 32; k++) begin
                b = i * 32 + k;
                rng = xs(rng);
                d[8*k+:8] = (b >= len) ? 8'h07 : (b == pos) ? ((mode == 2) ? rces_pkg::TERM_CHAR : 8'h07) :
                            (b == 12) ? lf[15:8] : (b == 13) ? lf[7:0] : rng[7:0];
                c[k] = (b >= len) || (b == pos);
            end
            drv(d, c, (i == 0) ? 4'h1 : 4'h0, (i == ncyc - 1) ? 4'h1 << ew : 4'h0,
                (i == ncyc - 1) ? em : 12'h000, (i == ncyc - 1) && cb);
            #1;
            if (i > 0) chk("mid", {rx_idle, rx_eop, rx_eop_empty, rx_error}, 0);
        end
        drv({32{8'h07}}, 32'hffffffff, 4'h0, 4'h0, 12'h000, 1'b0);
        #1;
        chk("eop", rx_eop, 4'h1 << ew);
        chk("empty", rx_eop_empty, em);
        chk("error", rx_error, last_exp);
        chk("fcs", rx_fcs_error, last_exp[1]);
        chk("idle", rx_idle, 4'(4'hf << (ew + 1)));
        drv({32{8'h07}}, 32'hffffffff, 4'h0, 4'h0, 12'h000, 1'b0);
        #1;
        chk("gap", {rx_idle, rx_eop, rx_error}, 14'h3c00);
        chk("client", last_err_q, last_exp);
    endtask

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        #500000;
        failures++;
        final_report();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, in_d, in_c, in_sop, in_eop, in_eop_empty, in_crc_bad} = '0;
        {failures, num_checks} = '0;
        frames_sent = 0;
        rng = 32'h0000815e;
        max_sz = 16'h05ee;
        plen_en = 1'b0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 16'h1418, 32'h0);
        chk("max reset", rd, 32'h000005ee);
        chk("mapped err", err, 0);
        apb(1'b0, 16'h1428, 32'h0);
        chk("plen reset", rd, 32'h0);
        apb(1'b0, 16'h1000, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("unmapped err", err, 1);
        apb(1'b1, 16'h1419, 32'h1);
        chk("unaligned", err, 1);
        foreach (corner_len[j]) send(corner_len[j], 16'h002e, 0, 1'b0);
        send(64, 16'h002e, 0, 1'b1);
        send(64, 16'h002e, 1, 1'b0);
        send(64, 16'h002e, 2, 1'b0);
        send(20, 16'h002e, 3, 1'b0);
        max_sz = 16'h0064;
        apb(1'b1, 16'h1418, 32'h64);
        plen_en = 1'b1;
        apb(1'b1, 16'h1428, 32'h1);
        apb(1'b0, 16'h1428, 32'h0);
        chk("plen on", rd, 32'h1);
        send(64, 16'h0028, 0, 1'b0);
        send(80, 16'h003e, 0, 1'b0);
        send(80, 16'h003d, 0, 1'b0);
        send(80, 16'h0600, 0, 1'b0);
        send(101, 16'h0053, 0, 1'b0);
        for (int i = 0; i < 40; i++) begin
            int          len;
            logic [15:0] lf;
            rng = xs(rng);
            len = 1 + int'(rng[15:0]) % 160;
            lf = (rng[17:16] == 2'h0) ? 16'(len - 18) : (rng[17:16] == 2'h1) ? {5'h00, rng[28:18]} :
                 16'h0600 + rng[25:18];
            if (i == 20) begin
                plen_en = 1'b0;
                apb(1'b1, 16'h1428, 32'h0);
            end
            send(len, lf, int'(rng[30:29]) % 3, rng[31] && len > 8);
        end
        apb(1'b0, 16'h1430, 32'h0);
        chk("status", rd[15:0], {10'h000, last_exp});
        chk("frames", rd[31:16], frames_sent[15:0]);
        final_report();
    end
endmodule
